// ===== design/rcm_top.sv
// reset, boot map, interrupt trap, clock mode and timer pulse control
// assumes a classic wishbone master and pins arriving asynchronously
//
// Behaviour
// - nmi traps regardless of disable and mask
// - reset low halts and holds pc zero
// - reset release fetches from address zero
// - strap low maps internal rom
// - strap high sends all fetches external
// - strap sampled in reset, software may override
// - machine clock rises at each cycle start
// - machine clock floats while float pin low
// - mode 00 external clock halved, no pll
// - mode 10 direct clock through pll
// - mode 11 oscillator on, pll off, halved
// - crystal clocking gives half input rate
// - oscillator drive output never floats
// - timer underflow emits a pulse
// - pulse lasts one machine clock period
// - global disable in bit nine, nmi unaffected
`timescale 1ns/1ps
`include "rcm_map.svh"

module rcm_top #(
  parameter int PC_W  = 16,
  parameter int IRQ_N = 4
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // wishbone slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  // board pins
  input  wire logic             reset_n_pin_i,
  input  wire logic             nonmaskable_irq_n_i,
  input  wire logic             boot_map_select_i,
  input  wire logic             clock_mode_sel_hi_i,
  input  wire logic             clock_mode_sel_lo_i,
  input  wire logic             crystal_in_i,
  input  wire logic             direct_clock_in_i,
  input  wire logic             output_float_n_i,
  output logic                  machine_clock_out_o,
  output logic                  machine_clock_out_oe_n_o,
  output logic                  crystal_drive_out_o,
  output logic                  timer_pulse_out_o,
  output logic                  osc_enable_o,
  output logic                  pll_enable_o,
  // core side
  input  wire logic [IRQ_N-1:0] irq_pending_i,
  input  wire logic             timer_underflow_i,
  output logic      [PC_W-1:0]  fetch_addr_o,
  output logic                  fetch_valid_o,
  output logic                  fetch_external_o,
  output logic                  rom_mapped_o,
  output logic                  cpu_halted_o,
  output logic                  irq_ack_o,
  output logic                  nmi_ack_o
);

  generate
    if (PC_W < 16 || PC_W > 16 || IRQ_N < 1 || IRQ_N > 16) begin : g_chk
      $error("rcm_top: PC_W must be 16 and IRQ_N 1..16");
    end
  endgenerate

  // register fields must fit the 32 bit data bus
  generate
    if (`RCM_ST_NMI_BIT > 31 || `RCM_GLOBAL_IRQ_DISABLE_BIT > 31) begin : g_map_chk
      $error("rcm_top: register field beyond data width");
    end
  endgenerate

  rcm_if cg ();

  rcm_clkgen u_clkgen (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .pins_i ({clock_mode_sel_lo_i, clock_mode_sel_hi_i,
              boot_map_select_i, output_float_n_i,
              nonmaskable_irq_n_i, reset_n_pin_i,
              direct_clock_in_i, crystal_in_i}),
    .cg     (cg.gen)
  );

  // register offset decode
  function automatic logic reg_hit(input logic [7:0] adr,
                                   input logic [7:0] off);
    reg_hit = (adr == off);
  endfunction : reg_hit

  logic                   req;
  logic                   wr;
  logic                   ack_r;
  logic [31:0]            rdat_r;
  logic                   mode_r;
  logic                   strap_r;
  logic                   global_irq_disable_r;
  logic [IRQ_N-1:0]       imr_r;
  logic [PC_W-1:0]        pc_r;
  logic [PC_W-1:0]        pc_nxt;
  rcm_pkg::rcm_state_e    state_r;
  rcm_pkg::rcm_state_e    state_nxt;
  logic                   nmi_pend_r;
  logic                   take_nmi_r;
  logic                   fetch_valid_r;
  logic [PC_W-1:0]        fetch_addr_r;
  logic                   fetch_ext_r;
  logic                   irq_ack_r;
  logic                   nmi_ack_r;
  logic                   arm_r;
  logic                   timer_pulse_out_r;
  logic                   mco_r;
  logic                   mco_oe_n_r;
  logic                   in_reset;
  logic                   irq_go;
  logic                   tick;
  logic                   global_irq_disable_wr;
  logic                   run_tick;
  logic                   trap_tick;

  // machine cycle boundaries in run and trap states
  assign run_tick  = tick && state_r == rcm_pkg::RCM_ST_RUN;
  assign trap_tick = tick && state_r == rcm_pkg::RCM_ST_TRAP;

  assign tick     = cg.mach_tick;
  assign in_reset = ~cg.pin_s[`RCM_PIN_RST_N];
  assign req      = wb_cyc_i & wb_stb_i;
  assign wr       = req & wb_we_i & ~ack_r;
  assign global_irq_disable_wr  = wr & reg_hit(wb_adr_i, `RCM_OFF_STATUS0) & wb_sel_i[1];

  // maskable gated by bit nine and mask only
  assign irq_go   = ~global_irq_disable_r & |(irq_pending_i & imr_r);

  // wishbone acknowledge, one wait state
  always_ff @(posedge clk_i) begin
    if (rst_i) ack_r <= 1'b0;
    else       ack_r <= req & ~ack_r;
  end

  // read data capture
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_r <= 32'h0000_0000;
    end else if (req & ~ack_r) begin
      rdat_r <= 32'h0000_0000;
      if (reg_hit(wb_adr_i, `RCM_OFF_MODE)) begin
        rdat_r[`RCM_MODE_BIT]                    <= mode_r;
        rdat_r[`RCM_STRAP_BIT]                   <= strap_r;
        rdat_r[`RCM_CLKMD_MSB:`RCM_CLKMD_LSB]    <= cg.clk_mode;
      end else if (reg_hit(wb_adr_i, `RCM_OFF_STATUS0)) begin
        rdat_r[`RCM_GLOBAL_IRQ_DISABLE_BIT]                    <= global_irq_disable_r;
      end else if (reg_hit(wb_adr_i, `RCM_OFF_IRQ_MASK)) begin
        rdat_r[IRQ_N-1:0]                        <= imr_r;
      end else if (reg_hit(wb_adr_i, `RCM_OFF_STATE)) begin
        rdat_r[`RCM_ST_PC_LSB+PC_W-1:`RCM_ST_PC_LSB] <= pc_r;
        rdat_r[`RCM_ST_HALT_BIT]                 <= in_reset;
        rdat_r[`RCM_ST_NMI_BIT]                  <= nmi_pend_r;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r  <= 1'b0;
      strap_r <= 1'b0;
    end else if (in_reset) begin
      mode_r  <= cg.pin_s[`RCM_PIN_BOOT];
      strap_r <= cg.pin_s[`RCM_PIN_BOOT];
    end else if (wr & reg_hit(wb_adr_i, `RCM_OFF_MODE) & wb_sel_i[0]) begin
      mode_r  <= wb_dat_i[`RCM_MODE_BIT];
    end
  end

  // global disable: hardware set on maskable trap wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i || in_reset) begin
      global_irq_disable_r <= `RCM_GLOBAL_IRQ_DISABLE_RST;
    end else if (state_r == rcm_pkg::RCM_ST_TRAP && tick && !take_nmi_r) begin
      global_irq_disable_r <= 1'b1;
    end else if (global_irq_disable_wr) begin
      global_irq_disable_r <= wb_dat_i[`RCM_GLOBAL_IRQ_DISABLE_BIT];
    end
  end

  // interrupt mask register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      imr_r <= '0;
    end else if (wr & reg_hit(wb_adr_i, `RCM_OFF_IRQ_MASK)) begin
      imr_r <= wb_dat_i[IRQ_N-1:0];
    end
  end

  // nmi latch from synchronised falling edge
  always_ff @(posedge clk_i) begin
    if (rst_i || in_reset) begin
      nmi_pend_r <= 1'b0;
    end else if (cg.nmi_fall) begin
      nmi_pend_r <= 1'b1;
    end else if (run_tick) begin
      nmi_pend_r <= 1'b0;
    end
  end

  // trap kind chosen when leaving run
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      take_nmi_r <= 1'b0;
    end else if (run_tick) begin
      take_nmi_r <= nmi_pend_r;
    end
  end

  // sequencer next state and pc
  always_comb begin
    state_nxt = state_r;
    pc_nxt    = pc_r;
    case (state_r)
      rcm_pkg::RCM_ST_RESET: begin
        pc_nxt = `RCM_PC_RST;
        if (!in_reset) state_nxt = rcm_pkg::RCM_ST_RUN;
      end
      rcm_pkg::RCM_ST_RUN: begin
        if (tick) begin
          if (nmi_pend_r || irq_go) begin
            state_nxt = rcm_pkg::RCM_ST_TRAP;
          end else begin
            pc_nxt = pc_r + 16'h0001;
          end
        end
      end
      rcm_pkg::RCM_ST_TRAP: begin
        if (tick) begin
          pc_nxt    = take_nmi_r ? `RCM_NMI_VEC : `RCM_IRQ_VEC;
          state_nxt = rcm_pkg::RCM_ST_RUN;
        end
      end
      default: begin
        state_nxt = rcm_pkg::RCM_ST_RESET;
        pc_nxt    = `RCM_PC_RST;
      end
    endcase
    if (in_reset) begin
      state_nxt = rcm_pkg::RCM_ST_RESET;
      pc_nxt    = `RCM_PC_RST;
    end
  end

  // sequencer registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= rcm_pkg::RCM_ST_RESET;
      pc_r    <= `RCM_PC_RST;
    end else begin
      state_r <= state_nxt;
      pc_r    <= pc_nxt;
    end
  end

  // fetch strobe, address and routing
  always_ff @(posedge clk_i) begin
    if (rst_i || in_reset) begin
      fetch_valid_r <= 1'b0;
      fetch_addr_r  <= `RCM_PC_RST;
      fetch_ext_r   <= 1'b0;
    end else begin
      fetch_valid_r <= tick && state_r == rcm_pkg::RCM_ST_RUN &&
                       !nmi_pend_r && !irq_go;
      if (tick && state_r == rcm_pkg::RCM_ST_RUN) begin
        fetch_addr_r <= pc_r;
        fetch_ext_r  <= mode_r | ({1'b0, pc_r} >= `RCM_ROM_WORDS);
      end
    end
  end

  // interrupt acknowledge pulses
  always_ff @(posedge clk_i) begin
    if (rst_i || in_reset) begin
      irq_ack_r <= 1'b0;
      nmi_ack_r <= 1'b0;
    end else begin
      irq_ack_r <= trap_tick && !take_nmi_r;
      nmi_ack_r <= trap_tick && take_nmi_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || in_reset) arm_r <= 1'b0;
    else                   arm_r <= timer_underflow_i | (arm_r & ~tick);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || in_reset) timer_pulse_out_r <= 1'b0;
    else if (tick)         timer_pulse_out_r <= arm_r;
  end

  // machine clock rises with each cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mco_r      <= 1'b0;
      mco_oe_n_r <= 1'b1;
    end else begin
      mco_r      <= cg.mco;
      mco_oe_n_r <= ~cg.pin_s[`RCM_PIN_FLOAT_N];
    end
  end

  assign wb_ack_o                 = ack_r;
  assign wb_dat_o                 = rdat_r;
  assign machine_clock_out_o      = mco_r;
  assign machine_clock_out_oe_n_o = mco_oe_n_r;
  assign crystal_drive_out_o      = cg.xdrv;
  assign timer_pulse_out_o        = timer_pulse_out_r;
  assign osc_enable_o             = cg.osc_en;
  assign pll_enable_o             = cg.pll_en;
  assign fetch_addr_o             = fetch_addr_r;
  assign fetch_valid_o            = fetch_valid_r;
  assign fetch_external_o         = fetch_ext_r;
  assign rom_mapped_o             = ~mode_r;
  assign cpu_halted_o             = state_r == rcm_pkg::RCM_ST_RESET;
  assign irq_ack_o                = irq_ack_r;
  assign nmi_ack_o                = nmi_ack_r;

endmodule : rcm_top

// ===== design/rcm_map.svh
// register offsets, field positions, reset values and vectors
// assumes inclusion by bare name from every design file that needs it
`ifndef RCM_MAP_SVH
`define RCM_MAP_SVH

// wishbone word offsets
`define RCM_OFF_MODE      8'h00
`define RCM_OFF_STATUS0   8'h04
`define RCM_OFF_IRQ_MASK  8'h08
`define RCM_OFF_STATE     8'h0C

// mode register fields
`define RCM_MODE_BIT      0
`define RCM_STRAP_BIT     1
`define RCM_CLKMD_LSB     2
`define RCM_CLKMD_MSB     3

// status word zero fields
`define RCM_GLOBAL_IRQ_DISABLE_BIT      9
`define RCM_GLOBAL_IRQ_DISABLE_RST      1'b1

// state register fields
`define RCM_ST_PC_LSB     0
`define RCM_ST_HALT_BIT   16
`define RCM_ST_NMI_BIT    17

// reset values and vectors
`define RCM_PC_RST        16'h0000
`define RCM_NMI_VEC       16'h0024
`define RCM_IRQ_VEC       16'h0002
`define RCM_ROM_WORDS     17'h01000

// synchronised pin positions
`define RCM_PIN_XTAL      0
`define RCM_PIN_DCLK      1
`define RCM_PIN_RST_N     2
`define RCM_PIN_NMI_N     3
`define RCM_PIN_FLOAT_N   4
`define RCM_PIN_BOOT      5
`define RCM_PIN_MD_HI     6
`define RCM_PIN_MD_LO     7
`define RCM_PIN_NUM       8

`endif

// ===== design/rcm_pkg.sv
// types shared by the reset and clock mode control block
// assumes nothing of its surroundings
package rcm_pkg;

  typedef enum logic [1:0] {
    RCM_CLK_EXT_DIV2 = 2'b00,
    RCM_CLK_TEST     = 2'b01,
    RCM_CLK_EXT_DIV1 = 2'b10,
    RCM_CLK_OSC_DIV2 = 2'b11
  } rcm_clk_mode_e;

  typedef enum logic [1:0] {
    RCM_ST_RESET = 2'b00,
    RCM_ST_RUN   = 2'b01,
    RCM_ST_TRAP  = 2'b10
  } rcm_state_e;

endpackage : rcm_pkg

// ===== design/rcm_if.sv
// carrier between the clock generator and the control core
// assumes both ends run on the one system clock
`timescale 1ns/1ps
`include "rcm_map.svh"

interface rcm_if;
  logic [`RCM_PIN_NUM-1:0] pin_s;
  logic                    pin_rise_xtal;
  logic                    nmi_fall;
  logic                    mach_tick;
  logic                    mco;
  logic                    osc_en;
  logic                    pll_en;
  logic                    xdrv;
  rcm_pkg::rcm_clk_mode_e  clk_mode;

  modport gen  (output pin_s, pin_rise_xtal, nmi_fall, mach_tick, mco,
                output osc_en, pll_en, xdrv, clk_mode);
  modport core (input  pin_s, pin_rise_xtal, nmi_fall, mach_tick, mco,
                input  osc_en, pll_en, xdrv, clk_mode);
endinterface : rcm_if

// ===== design/rcm_clkgen.sv
// pin synchronisers and machine clock generation
// assumes clk_i is much faster than crystal_in and direct_clock_in
`timescale 1ns/1ps
`include "rcm_map.svh"

module rcm_clkgen (
  input  wire logic           clk_i,
  input  wire logic           rst_i,
  input  wire logic [`RCM_PIN_NUM-1:0] pins_i,
  rcm_if.gen                  cg
);

  logic [`RCM_PIN_NUM-1:0] s1_r;
  logic [`RCM_PIN_NUM-1:0] s2_r;
  logic [`RCM_PIN_NUM-1:0] s3_r;
  logic                    phase_r;
  logic                    mco_r;
  logic                    tick_r;
  logic                    xdrv_r;
  logic                    xr;
  logic                    dr;
  logic                    df;
  rcm_pkg::rcm_clk_mode_e  mode;

  genvar g;
  generate
    for (g = 0; g < `RCM_PIN_NUM; g = g + 1) begin : g_sync
      always_ff @(posedge clk_i) begin
        s1_r[g] <= pins_i[g];
        s2_r[g] <= s1_r[g];
        s3_r[g] <= s2_r[g];
      end
    end
  endgenerate

  assign mode = rcm_pkg::rcm_clk_mode_e'({s2_r[`RCM_PIN_MD_HI],
                                          s2_r[`RCM_PIN_MD_LO]});
  assign xr   = s2_r[`RCM_PIN_XTAL] & ~s3_r[`RCM_PIN_XTAL];
  assign dr   = s2_r[`RCM_PIN_DCLK] & ~s3_r[`RCM_PIN_DCLK];
  assign df   = ~s2_r[`RCM_PIN_DCLK] & s3_r[`RCM_PIN_DCLK];

  always_ff @(posedge clk_i) begin
    tick_r <= 1'b0;
    if (rst_i) begin
      phase_r <= 1'b0;
      mco_r   <= 1'b0;
    end else begin
      case (mode)
        rcm_pkg::RCM_CLK_EXT_DIV2, rcm_pkg::RCM_CLK_OSC_DIV2: begin
          if (xr) begin
            phase_r <= ~phase_r;
            mco_r   <= ~phase_r;
            tick_r  <= ~phase_r;
          end
        end
        rcm_pkg::RCM_CLK_EXT_DIV1: begin
          if (dr) begin
            mco_r  <= 1'b1;
            tick_r <= 1'b1;
          end else if (df) begin
            mco_r  <= 1'b0;
          end
        end
        default: begin
          mco_r   <= 1'b0;
          phase_r <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) xdrv_r <= 1'b0;
    else       xdrv_r <= (mode == rcm_pkg::RCM_CLK_OSC_DIV2) &
                         ~s2_r[`RCM_PIN_XTAL];
  end

  assign cg.pin_s         = s2_r;
  assign cg.pin_rise_xtal = xr;
  assign cg.nmi_fall      = ~s2_r[`RCM_PIN_NMI_N] & s3_r[`RCM_PIN_NMI_N];
  assign cg.mach_tick     = tick_r;
  assign cg.mco           = mco_r;
  assign cg.osc_en        = (mode == rcm_pkg::RCM_CLK_OSC_DIV2);
  assign cg.pll_en        = (mode == rcm_pkg::RCM_CLK_EXT_DIV1);
  assign cg.xdrv          = xdrv_r;
  assign cg.clk_mode      = mode;

endmodule : rcm_clkgen

// ===== dv/rcm_top_asserts.sv
// concurrent checks on the reset and clock mode control top ports
// assumes a bind onto rcm_top, one clock, synchronous reset
`timescale 1ns/1ps
`include "rcm_map.svh"

module rcm_top_asserts #(
  parameter int PC_W = 16
) (
  input wire logic            clk_i,
  input wire logic            rst_i,
  input wire logic            reset_n_pin_i,
  input wire logic            boot_map_select_i,
  input wire logic            clock_mode_sel_hi_i,
  input wire logic            clock_mode_sel_lo_i,
  input wire logic            output_float_n_i,
  input wire logic            timer_underflow_i,
  input wire logic            machine_clock_out_o,
  input wire logic            machine_clock_out_oe_n_o,
  input wire logic            timer_pulse_out_o,
  input wire logic            osc_enable_o,
  input wire logic            pll_enable_o,
  input wire logic [PC_W-1:0] fetch_addr_o,
  input wire logic            fetch_valid_o,
  input wire logic            fetch_external_o,
  input wire logic            rom_mapped_o,
  input wire logic            cpu_halted_o,
  input wire logic            irq_ack_o,
  input wire logic            nmi_ack_o
);
  logic            first_r;
  logic            vec_v_r;
  logic [PC_W-1:0] vec_r;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // marks the first fetch after reset and the fetch after a trap
  always_ff @(posedge clk_i) begin
    if (rst_i || cpu_halted_o) first_r <= 1'b1;
    else if (fetch_valid_o) first_r <= 1'b0;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || fetch_valid_o) vec_v_r <= 1'b0;
    else if (nmi_ack_o || irq_ack_o) vec_v_r <= 1'b1;
  end
  always_ff @(posedge clk_i) begin
    if (nmi_ack_o) vec_r <= PC_W'(`RCM_NMI_VEC);
    else if (irq_ack_o) vec_r <= PC_W'(`RCM_IRQ_VEC);
  end

  property p_float;
    $stable(output_float_n_i)[*5] |->
      machine_clock_out_oe_n_o == !output_float_n_i;
  endproperty
  a_float: assert property (p_float)
    else $error("machine clock enable does not follow float pin");
  property p_halt;
    (!reset_n_pin_i)[*5] |-> cpu_halted_o && !fetch_valid_o;
  endproperty
  a_halt: assert property (p_halt)
    else $error("fetch or run while reset pin low");
  property p_first;
    fetch_valid_o && first_r |-> fetch_addr_o == '0;
  endproperty
  a_first: assert property (p_first)
    else $error("first fetch after reset not at zero");
  property p_vec;
    fetch_valid_o && vec_v_r |-> fetch_addr_o == vec_r;
  endproperty
  a_vec: assert property (p_vec)
    else $error("fetch after trap not at vector");
  property p_ext;
    fetch_valid_o && !$past(rom_mapped_o) |-> fetch_external_o;
  endproperty
  a_ext: assert property (p_ext)
    else $error("internal fetch in external mode");
  property p_rom;
    fetch_valid_o && $past(rom_mapped_o) && fetch_addr_o < `RCM_ROM_WORDS
      |-> !fetch_external_o;
  endproperty
  a_rom: assert property (p_rom)
    else $error("rom fetch routed external");
  property p_strap;
    (!reset_n_pin_i && $stable(boot_map_select_i))[*6] |->
      rom_mapped_o == !boot_map_select_i;
  endproperty
  a_strap: assert property (p_strap)
    else $error("boot strap not taken during reset");
  property p_clk_en;
    $stable({clock_mode_sel_hi_i, clock_mode_sel_lo_i})[*4] |->
      pll_enable_o == (clock_mode_sel_hi_i && !clock_mode_sel_lo_i) &&
      osc_enable_o == (clock_mode_sel_hi_i && clock_mode_sel_lo_i);
  endproperty
  a_clk_en: assert property (p_clk_en)
    else $error("oscillator or pll enable wrong for mode");
  property p_pulse_edge;
    $changed(timer_pulse_out_o) && !cpu_halted_o |->
      $rose(machine_clock_out_o);
  endproperty
  a_pulse_edge: assert property (p_pulse_edge)
    else $error("timer pulse edge off machine clock rise");
  property p_pulse_cause;
    timer_underflow_i && !cpu_halted_o |-> ##[1:40] timer_pulse_out_o;
  endproperty
  a_pulse_cause: assert property (p_pulse_cause)
    else $error("no timer pulse after underflow");
endmodule : rcm_top_asserts

// ===== dv/rcm_board.sv
// board model: free running crystal and direct clocks, mode straps
// assumes the bench picks the requested clock mode
`timescale 1ns/1ps

module rcm_board (
  input  wire logic [1:0] mode_req_i,
  output logic            md_hi_o,
  output logic            md_lo_o,
  output logic            xtal_o,
  output logic            dclk_o
);
  initial begin
    xtal_o = 1'b0;
    #7;
    forever #80 xtal_o = ~xtal_o;
  end
  initial begin
    dclk_o = 1'b0;
    #3;
    forever #60 dclk_o = ~dclk_o;
  end
  assign {md_hi_o, md_lo_o} = (mode_req_i == 2'b01) ? 2'b00 : mode_req_i;
endmodule : rcm_board

// ===== dv/reset_clock_mode_control_bench.sv
// self-checking bench for the reset and clock mode control block
// assumes rcm_top, the board model and the checker are compiled
`timescale 1ns/1ps
`include "rcm_map.svh"

module reset_clock_mode_control_bench;
  localparam int PC_W = 16;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [7:0]  adr = '0;
  logic [31:0] dat = '0, wb_dat_o;
  logic        wb_ack_o, rst_n = 0, nmi_n = 1, boot = 0, fl_n = 1, tuf = 0;
  logic        md_hi, md_lo, xtal, dclk, mco, oe_n, xdrv, timer_pulse_out, osc, pll;
  logic [1:0]  mode_req = 2'b00;
  logic [3:0]  pend = '0;
  logic [15:0] fa;
  logic        fv, fext, rom_m, halted, irq_ack, nmi_ack;
  logic [31:0] exp_q[$];
  int          miscompares = 0, samples_checked = 0, cyc_n = 0;
  int          seed = 9055, p;

  rcm_top #(.PC_W(PC_W), .IRQ_N(4)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .reset_n_pin_i(rst_n),
    .nonmaskable_irq_n_i(nmi_n), .boot_map_select_i(boot),
    .clock_mode_sel_hi_i(md_hi), .clock_mode_sel_lo_i(md_lo),
    .crystal_in_i(xtal), .direct_clock_in_i(dclk), .output_float_n_i(fl_n),
    .machine_clock_out_o(mco), .machine_clock_out_oe_n_o(oe_n),
    .crystal_drive_out_o(xdrv), .timer_pulse_out_o(timer_pulse_out),
    .osc_enable_o(osc), .pll_enable_o(pll), .irq_pending_i(pend),
    .timer_underflow_i(tuf), .fetch_addr_o(fa), .fetch_valid_o(fv),
    .fetch_external_o(fext), .rom_mapped_o(rom_m), .cpu_halted_o(halted),
    .irq_ack_o(irq_ack), .nmi_ack_o(nmi_ack));
  rcm_board board (.mode_req_i(mode_req), .md_hi_o(md_hi), .md_lo_o(md_lo),
    .xtal_o(xtal), .dclk_o(dclk));

  always #10 clk_i = ~clk_i;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out;
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask : rd

  // waits for fetch, nmi ack, irq ack or timer pulse
  task automatic wait_hi(input int s);
    int   n;
    logic v;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
      case (s)
        0: v = fv;
        1: v = nmi_ack;
        2: v = irq_ack;
        default: v = timer_pulse_out;
      endcase
    end while (v !== 1'b1 && n < 300);
    check(v, 1'b1);
  endtask : wait_hi

  task automatic mco_period(output int q);
    int n;
    repeat (2) begin
      n = 0;
      while (mco === 1'b1 && n < 100) begin
        @(posedge clk_i);
        n++;
      end
      while (mco !== 1'b1 && n < 200) begin
        @(posedge clk_i);
        n++;
      end
      q = n;
    end
  endtask : mco_period

  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && we === 1'b0 && exp_q.size() > 0)
      check(wb_dat_o, exp_q.pop_front());
  end

  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 40000) begin
      miscompares++;
      close_out();
    end
  end

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`RCM_OFF_MODE, 32'h0);
    rd(`RCM_OFF_STATUS0, 32'h200);
    rd(`RCM_OFF_IRQ_MASK, 32'h0);
    rd(`RCM_OFF_STATE, 32'h10000);
    wb(1'b1, 8'h10, 32'hFFFFFFFF);
    rd(8'h10, 32'h0);
    repeat (3) begin
      p = $random(seed);
      pend <= p[3:0];
      wb(1'b1, `RCM_OFF_IRQ_MASK, p);
      rd(`RCM_OFF_IRQ_MASK, {28'h0, p[3:0]});
    end
    rst_n <= 1'b1;
    wait_hi(0);
    check(fa, 16'h0);
    check(fext, 1'b0);
    wb(1'b1, `RCM_OFF_MODE, 32'hF);
    rd(`RCM_OFF_MODE, 32'h1);
    wait_hi(0);
    check(fext, 1'b1);
    tuf <= 1'b1;
    @(posedge clk_i);
    tuf <= 1'b0;
    wait_hi(3);
    p = 0;
    while (timer_pulse_out === 1'b1 && p < 100) begin
      @(posedge clk_i);
      p++;
    end
    check(p, 16);
    for (int m = 0; m < 4; m++) begin
      mode_req <= m[1:0];
      repeat (40) @(posedge clk_i);
      mco_period(p);
      check(p, (m == 2) ? 6 : 16);
      check({osc, pll}, {m == 3, m == 2});
    end
    fl_n <= 1'b0;
    repeat (6) @(posedge clk_i);
    check(oe_n, 1'b1);
    p = 0;
    repeat (32) begin
      @(posedge clk_i);
      if (xdrv === 1'b1) p++;
    end
    check(p, 16);
    fl_n <= 1'b1;
    mode_req <= 2'b00;
    repeat (6) @(posedge clk_i);
    check(oe_n, 1'b0);
    wb(1'b1, `RCM_OFF_IRQ_MASK, 32'hF);
    pend <= '0;
    wb(1'b1, `RCM_OFF_STATUS0, 32'h200);
    nmi_n <= 1'b0;
    repeat (4) @(posedge clk_i);
    nmi_n <= 1'b1;
    wait_hi(1);
    wait_hi(0);
    check(fa, `RCM_NMI_VEC);
    pend <= 4'h1;
    wb(1'b1, `RCM_OFF_STATUS0, 32'h0);
    wait_hi(2);
    pend <= '0;
    wait_hi(0);
    check(fa, `RCM_IRQ_VEC);
    rd(`RCM_OFF_STATUS0, 32'h200);
    rst_n <= 1'b0;
    boot <= 1'b1;
    repeat (8) @(posedge clk_i);
    check(halted, 1'b1);
    rd(`RCM_OFF_MODE, 32'h3);
    rst_n <= 1'b1;
    wait_hi(0);
    check(fa, 16'h0);
    check(fext, 1'b1);
    close_out();
  end
endmodule : reset_clock_mode_control_bench

bind rcm_top rcm_top_asserts #(.PC_W(PC_W)) u_chk (.clk_i(clk_i),
  .rst_i(rst_i), .reset_n_pin_i(reset_n_pin_i),
  .boot_map_select_i(boot_map_select_i),
  .clock_mode_sel_hi_i(clock_mode_sel_hi_i),
  .clock_mode_sel_lo_i(clock_mode_sel_lo_i),
  .output_float_n_i(output_float_n_i), .timer_underflow_i(timer_underflow_i),
  .machine_clock_out_o(machine_clock_out_o),
  .machine_clock_out_oe_n_o(machine_clock_out_oe_n_o),
  .timer_pulse_out_o(timer_pulse_out_o), .osc_enable_o(osc_enable_o),
  .pll_enable_o(pll_enable_o), .fetch_addr_o(fetch_addr_o),
  .fetch_valid_o(fetch_valid_o), .fetch_external_o(fetch_external_o),
  .rom_mapped_o(rom_mapped_o), .cpu_halted_o(cpu_halted_o),
  .irq_ack_o(irq_ack_o), .nmi_ack_o(nmi_ack_o));
